// >>> shared/pmu_pkg.sv
// package for the power monitor unit register block
// assumes a 32-bit avalon-mm register bus with word addressing by byte offset
package pmu_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_POWER_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_RETAINED_0     = 8'h04;
   localparam logic [7:0] OFS_RETAINED_1     = 8'h08;
   localparam logic [7:0] OFS_RETAINED_2     = 8'h0C;
   localparam logic [7:0] OFS_RETAINED_3     = 8'h10;
   localparam logic [7:0] OFS_RETAINED_WAKE  = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS     = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'h1C;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_DEEP_PD_EN       = 1;
   localparam int BIT_SLEEP_FLAG       = 8;
   localparam int BIT_DEEP_PD_FLAG     = 11;
   localparam int BIT_WAKE_HYS         = 10;
   localparam int RETAINED_LOW_BIT     = 11;
   localparam int BIT_IRQ_SLEEP        = 0;
   localparam int BIT_IRQ_DEEP_PD      = 1;
   localparam int NUM_IRQ              = 2;
   localparam int NUM_RETAINED         = 4;
   // ----------------------------------------
   // reset values and constants
   // ----------------------------------------
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
   localparam logic [1:0]  RESP_OK     = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
   // power modes: active and the two sleep entry kinds
   typedef enum logic [1:0] {
      PMU_ACTIVE   = 2'b00,
      PMU_SLEEP    = 2'b01,
      PMU_DEEP_PD  = 2'b10
   } pmu_mode_t;
endpackage

// >>> src/pmu_retained_bank.sv
// retained word bank, cleared only by the cold start reset
// assumes write strobes already decoded by the register slave
`timescale 1ns/1ps
module pmu_retained_bank
   import pmu_pkg::*;
#(
   parameter int N_WORDS = NUM_RETAINED
)(
   // clock and cold reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_cold_rst,
   // write side
   input  wire logic [N_WORDS-1:0]     i_wr_en,
   input  wire logic [31:0]            i_wr_data,
   input  wire logic [3:0]             i_wr_be,
   // stored words
   output logic      [N_WORDS*32-1:0]  o_words
);
   initial begin
      if (N_WORDS < 1) begin
         $error("pmu_retained_bank needs at least one word");
      end
   end

   logic [31:0] word_ff [N_WORDS];
   logic [31:0] nxt_word [N_WORDS];

   // ----------------------------------------
   // per-word storage
   // ----------------------------------------
   for (genvar w = 0; w < N_WORDS; w++) begin : g_word
      always_comb begin
         nxt_word[w] = word_ff[w];
         for (int b = 0; b < 4; b++) begin
            if (i_wr_en[w] && i_wr_be[b]) begin
               nxt_word[w][b*8 +: 8] = i_wr_data[b*8 +: 8];
            end
         end
      end
      // only cold start clears, deep power-down wake does not
      always_ff @(posedge i_ref_clk or posedge i_cold_rst) begin
         if (i_cold_rst) begin
            word_ff[w] <= RST_WORD;
         end else begin
            word_ff[w] <= nxt_word[w];
         end
      end
      assign o_words[w*32 +: 32] = word_ff[w];
   end
endmodule

// >>> src/pmu_ctrl_regs.sv
// power monitor unit register block: sleep mode select, entry flags, retained words
// assumes cold start on i_sys_rst, wake-up reset from deep power-down on i_wake_rst
// Operation
// - enable bit 1 clear: wait-for-interrupt enters sleep, only core clock gated
// - enable bit 1 set: wait-for-interrupt enters deep power-down, core powered off
// - sleep flag bit 8 reads 1 after any sleep or deep power-down entry
// - writing 1 clears sleep flag, writing 0 leaves it
// - deep power-down flag bit 11 reads 1 after deep power-down entry
// - writing 1 clears deep power-down flag, writing 0 does nothing
// - four retained words survive deep power-down, cleared only by cold start
// - fifth word bits 31:11 retained likewise, cleared only by cold start
// - fifth word bit 10 enables wake pin hysteresis, resets to 0
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module pmu_ctrl_regs
   import pmu_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   // clock and resets
   input  wire logic               i_ref_clk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_wake_rst,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0]  i_avs_address,
   input  wire logic               i_avs_read,
   input  wire logic               i_avs_write,
   input  wire logic [31:0]        i_avs_writedata,
   input  wire logic [3:0]         i_avs_byteenable,
   output logic      [31:0]        o_avs_readdata,
   output logic      [1:0]         o_avs_response,
   output logic                    o_avs_waitrequest,
   // processor sleep handshake
   input  wire logic               i_wfi_req,
   output logic                    o_core_clk_gate,
   output logic                    o_core_power_off,
   // wake pin and interrupt
   output logic                    o_wake_pin_hys_en,
   output logic                    o_irq
);
   initial begin
      if (ADDR_W < 5) begin
         $error("pmu_ctrl_regs needs at least 5 address bits");
      end
   end

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   // one wait cycle per access: request taken, then answered on the next edge
   logic        ack_ff;
   logic        nxt_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0]  resp_ff;
   logic [1:0]  nxt_resp;

   logic        req;
   logic        wr_do;
   logic [7:0]  ofs;
   logic        hit;
   logic [31:0] be_mask;

   assign req   = (i_avs_read || i_avs_write) && !ack_ff;
   assign wr_do = i_avs_write && !ack_ff;
   assign ofs   = 8'(i_avs_address);

   always_comb begin
      be_mask = '0;
      for (int b = 0; b < 4; b++) begin
         be_mask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
      end
   end

   // ----------------------------------------
   // control and flag state
   // ----------------------------------------
   logic                deep_pd_en_ff;
   logic                nxt_deep_pd_en;
   logic                sleep_flag_ff;
   logic                nxt_sleep_flag;
   logic                deep_pd_flag_ff;
   logic                nxt_deep_pd_flag;
   logic [31:0]         wake_word_ff;
   logic [31:0]         nxt_wake_word;
   logic [NUM_IRQ-1:0]  irq_stat_ff;
   logic [NUM_IRQ-1:0]  nxt_irq_stat;
   logic [NUM_IRQ-1:0]  irq_mask_ff;
   logic [NUM_IRQ-1:0]  nxt_irq_mask;
   pmu_mode_t           mode_ff;
   pmu_mode_t           nxt_mode;
   logic                wfi_d_ff;
   logic                nxt_wfi_d;

   logic        wfi_rise;
   logic        wr_ctrl;
   logic [31:0] wd;

   assign wfi_rise = i_wfi_req && !wfi_d_ff;
   assign wr_ctrl  = wr_do && (ofs == OFS_POWER_CONTROL);
   assign wd       = i_avs_writedata & be_mask;

   // retained words 0..3 in the bank
   logic [NUM_RETAINED-1:0]    bank_wr;
   logic [NUM_RETAINED*32-1:0] bank_words;

   always_comb begin
      bank_wr = '0;
      if (wr_do) begin
         unique case (ofs)
            OFS_RETAINED_0: bank_wr[0] = 1'b1;
            OFS_RETAINED_1: bank_wr[1] = 1'b1;
            OFS_RETAINED_2: bank_wr[2] = 1'b1;
            OFS_RETAINED_3: bank_wr[3] = 1'b1;
            default:        bank_wr    = '0;
         endcase
      end
   end

   pmu_retained_bank #(
      .N_WORDS (NUM_RETAINED)
   ) u_bank (
      .i_ref_clk  (i_ref_clk),
      .i_cold_rst (i_sys_rst),
      .i_wr_en    (bank_wr),
      .i_wr_data  (i_avs_writedata),
      .i_wr_be    (i_avs_byteenable),
      .o_words    (bank_words)
   );

   // ----------------------------------------
   // mode select and flag update
   // ----------------------------------------
   always_comb begin
      nxt_deep_pd_en   = deep_pd_en_ff;
      nxt_sleep_flag   = sleep_flag_ff;
      nxt_deep_pd_flag = deep_pd_flag_ff;
      nxt_mode         = mode_ff;
      nxt_wfi_d        = i_wfi_req;
      if (wr_ctrl) begin
         if (i_avs_byteenable[0]) begin
            nxt_deep_pd_en = i_avs_writedata[BIT_DEEP_PD_EN];
         end
         if (wd[BIT_SLEEP_FLAG]) begin
            nxt_sleep_flag = 1'b0;
         end
         if (wd[BIT_DEEP_PD_FLAG]) begin
            nxt_deep_pd_flag = 1'b0;
         end
      end
      // wake ends any low power mode
      if (!i_wfi_req) begin
         nxt_mode = PMU_ACTIVE;
      end
      // set wins over a clear in the same cycle
      if (wfi_rise) begin
         nxt_sleep_flag = 1'b1;
         if (deep_pd_en_ff) begin
            nxt_mode         = PMU_DEEP_PD;
            nxt_deep_pd_flag = 1'b1;
         end else begin
            nxt_mode = PMU_SLEEP;
         end
      end
   end

   // flags survive the wake reset; only cold start clears them
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sleep_flag_ff   <= 1'b0;
         deep_pd_flag_ff <= 1'b0;
      end else begin
         sleep_flag_ff   <= nxt_sleep_flag;
         deep_pd_flag_ff <= nxt_deep_pd_flag;
      end
   end

   // enable and mode clear on either reset, core restarts after deep power-down
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         deep_pd_en_ff <= 1'b0;
         mode_ff       <= PMU_ACTIVE;
         wfi_d_ff      <= 1'b0;
      end else if (i_wake_rst) begin
         deep_pd_en_ff <= 1'b0;
         mode_ff       <= PMU_ACTIVE;
         wfi_d_ff      <= 1'b0;
      end else begin
         deep_pd_en_ff <= nxt_deep_pd_en;
         mode_ff       <= nxt_mode;
         wfi_d_ff      <= nxt_wfi_d;
      end
   end

   // ----------------------------------------
   // fifth retained word
   // ----------------------------------------
   always_comb begin
      nxt_wake_word = wake_word_ff;
      if (wr_do && (ofs == OFS_RETAINED_WAKE)) begin
         // low reserved bits are never stored
         nxt_wake_word = (i_avs_writedata & be_mask) | (wake_word_ff & ~be_mask);
         nxt_wake_word[BIT_WAKE_HYS-1:0] = '0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_word_ff <= RST_WORD;
      end else begin
         wake_word_ff <= nxt_wake_word;
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   always_comb begin
      nxt_irq_stat = irq_stat_ff;
      nxt_irq_mask = irq_mask_ff;
      if (wr_do && (ofs == OFS_IRQ_STATUS)) begin
         nxt_irq_stat = irq_stat_ff & ~wd[NUM_IRQ-1:0];
      end
      if (wr_do && (ofs == OFS_IRQ_MASK)) begin
         nxt_irq_mask = wd[NUM_IRQ-1:0] | (irq_mask_ff & ~be_mask[NUM_IRQ-1:0]);
      end
      if (wfi_rise) begin
         nxt_irq_stat[BIT_IRQ_SLEEP] = 1'b1;
         if (deep_pd_en_ff) begin
            nxt_irq_stat[BIT_IRQ_DEEP_PD] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
      end
   end

   // ----------------------------------------
   // read mux and answer
   // ----------------------------------------
   always_comb begin
      hit = 1'b1;
      unique case (ofs)
         OFS_POWER_CONTROL: begin
            nxt_rdata                   = '0;
            nxt_rdata[BIT_DEEP_PD_EN]   = deep_pd_en_ff;
            nxt_rdata[BIT_SLEEP_FLAG]   = sleep_flag_ff;
            nxt_rdata[BIT_DEEP_PD_FLAG] = deep_pd_flag_ff;
         end
         OFS_RETAINED_0:    nxt_rdata = bank_words[0*32 +: 32];
         OFS_RETAINED_1:    nxt_rdata = bank_words[1*32 +: 32];
         OFS_RETAINED_2:    nxt_rdata = bank_words[2*32 +: 32];
         OFS_RETAINED_3:    nxt_rdata = bank_words[3*32 +: 32];
         OFS_RETAINED_WAKE: nxt_rdata = wake_word_ff;
         OFS_IRQ_STATUS:    nxt_rdata = 32'(irq_stat_ff);
         OFS_IRQ_MASK:      nxt_rdata = 32'(irq_mask_ff);
         default: begin
            nxt_rdata = UNMAPPED_RD;
            hit       = 1'b0;
         end
      endcase
      nxt_ack  = req;
      nxt_resp = hit ? RESP_OK : RESP_DECERR;
      if (!req) begin
         nxt_rdata = rdata_ff;
         nxt_resp  = resp_ff;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= RST_WORD;
         resp_ff  <= RESP_OK;
      end else begin
         ack_ff   <= nxt_ack;
         rdata_ff <= nxt_rdata;
         resp_ff  <= nxt_resp;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   logic core_gate_ff;
   logic core_off_ff;
   logic hys_ff;
   logic irq_ff;

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         core_gate_ff <= 1'b0;
         core_off_ff  <= 1'b0;
         hys_ff       <= 1'b0;
         irq_ff       <= 1'b0;
      end else begin
         core_gate_ff <= (nxt_mode == PMU_SLEEP);
         core_off_ff  <= (nxt_mode == PMU_DEEP_PD);
         hys_ff       <= nxt_wake_word[BIT_WAKE_HYS];
         irq_ff       <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   // waitrequest low only in the answer cycle
   assign o_avs_waitrequest = !ack_ff;
   assign o_avs_readdata    = rdata_ff;
   assign o_avs_response    = resp_ff;
   assign o_core_clk_gate   = core_gate_ff;
   assign o_core_power_off  = core_off_ff;
   assign o_wake_pin_hys_en = hys_ff;
   assign o_irq             = irq_ff;
endmodule

// >>> tb/pmu_core_model.sv
// core model: raises wait-for-interrupt on request, wakes after a hold count
// assumes the bench pulses i_go for one cycle and keeps i_hold steady
`timescale 1ns/1ps
module pmu_core_model (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   // sleep request from the bench
   input  wire logic       i_go,
   input  wire logic [7:0] i_hold,
   // to the block
   output logic            o_wfi_req
);
   logic [7:0] cnt_ff;
   // hold count running out ends the wait; small hold is a prompt wake, large a slow one
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_wfi_req <= 1'b0;
         cnt_ff    <= 8'h00;
      end else if (i_go) begin
         o_wfi_req <= 1'b1;
         cnt_ff    <= i_hold;
      end else if (cnt_ff != 8'h00) begin
         cnt_ff <= cnt_ff - 8'h01;
      end else begin
         o_wfi_req <= 1'b0;
      end
   end
endmodule

// >>> tb/pmu_ctrl_checker.sv
// assertions for the power monitor register block
// sees only the block's ports; bound from the bench top file
`timescale 1ns/1ps
module pmu_ctrl_checker
   import pmu_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   // watched ports
   input  wire logic              i_ref_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_wake_rst,
   input  wire logic [ADDR_W-1:0] i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   input  wire logic [31:0]       o_avs_readdata,
   input  wire logic [1:0]        o_avs_response,
   input  wire logic              o_avs_waitrequest,
   input  wire logic              i_wfi_req,
   input  wire logic              o_core_clk_gate,
   input  wire logic              o_core_power_off,
   input  wire logic              o_wake_pin_hys_en,
   input  wire logic              o_irq
);
   logic take, wr0, wake_wr, rise;
   logic wfi_q_ff, en_ff, sflag_ff, dflag_ff, hys_ff;
   assign take    = (i_avs_read | i_avs_write) & o_avs_waitrequest;
   assign wr0     = take & i_avs_write & (i_avs_address == ADDR_W'(OFS_POWER_CONTROL));
   assign wake_wr = take & i_avs_write & i_avs_byteenable[1]
                  & (i_avs_address == ADDR_W'(OFS_RETAINED_WAKE));
   assign rise    = i_wfi_req & ~wfi_q_ff;
   // shadow of the control word; set wins over a clear in the same cycle
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         {wfi_q_ff, en_ff, sflag_ff, dflag_ff, hys_ff} <= 5'h00;
      end else begin
         wfi_q_ff <= i_wfi_req & ~i_wake_rst;
         if (i_wake_rst)
            en_ff <= 1'b0;
         else if (wr0 & i_avs_byteenable[0])
            en_ff <= i_avs_writedata[BIT_DEEP_PD_EN];
         sflag_ff <= rise | (sflag_ff & ~(wr0 & i_avs_byteenable[1] & i_avs_writedata[8]));
         dflag_ff <= (rise & en_ff)
                   | (dflag_ff & ~(wr0 & i_avs_byteenable[1] & i_avs_writedata[11]));
         if (wake_wr)
            hys_ff <= i_avs_writedata[BIT_WAKE_HYS];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   wait_low_a: assert property (take |=> !o_avs_waitrequest)
      else $error("access not answered next cycle");
   wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer longer than one cycle");
   idle_wait_a: assert property (
      !i_avs_read && !i_avs_write && o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer without request");
   unmapped_a: assert property (
      take && i_avs_address > 8'h1C |=> o_avs_response == 2'h3 && o_avs_readdata == 32'h0)
      else $error("unmapped access not refused");
   ctrl_read_a: assert property (
      take && i_avs_read && i_avs_address == 8'h00 |=>
      o_avs_readdata == {20'h0, $past(dflag_ff), 2'h0, $past(sflag_ff), 6'h0, $past(en_ff), 1'h0})
      else $error("control word readback wrong");
   sleep_gate_a: assert property (
      rise && !en_ff && !i_wake_rst |=> o_core_clk_gate && !o_core_power_off)
      else $error("sleep entry wrong");
   deep_off_a: assert property (
      rise && en_ff && !i_wake_rst |=> o_core_power_off && !o_core_clk_gate)
      else $error("deep power-down entry wrong");
   wake_drop_a: assert property (
      !i_wfi_req |=> !o_core_clk_gate && !o_core_power_off)
      else $error("core held off after wake");
   hys_copy_a: assert property (wake_wr |=> ##[0:1] o_wake_pin_hys_en == hys_ff)
      else $error("hysteresis output wrong");
   irq_fall_a: assert property ($fell(o_irq) |-> $past(i_avs_write))
      else $error("interrupt dropped without a write");
   cover property ($rose(o_core_clk_gate));
   cover property ($rose(o_core_power_off));
   cover property ($rose(o_irq));
endmodule

// >>> tb/pmu_ctrl_regs_bench.sv
// bench for the power monitor register block
// assumes pmu_pkg, design, core model and checker are compiled first
`timescale 1ns/1ps
module pmu_ctrl_regs_bench;
   import pmu_pkg::*;
   logic        i_ref_clk, i_sys_rst, i_wake_rst, i_avs_read, i_avs_write, go;
   logic [7:0]  i_avs_address, hold;
   logic [31:0] i_avs_writedata, o_avs_readdata, q;
   logic [3:0]  i_avs_byteenable;
   logic [1:0]  o_avs_response, resp_q;
   logic        o_avs_waitrequest, i_wfi_req, o_core_clk_gate, o_core_power_off;
   logic        o_wake_pin_hys_en, o_irq;
   int          error_cnt = 0;
   int          tests_run = 0;
   pmu_ctrl_regs i_dut (.*);
   pmu_core_model i_core (.i_ref_clk, .i_sys_rst, .i_go(go), .i_hold(hold), .o_wfi_req(i_wfi_req));
   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // holds the request until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) error_cnt++;
      q = o_avs_readdata;
      resp_q = o_avs_response;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // one wait-for-interrupt with wake after h cycles; checks both core outputs
   task automatic nap(input logic g, input logic o, input logic [7:0] h);
      @(posedge i_ref_clk);
      go <= 1'b1;
      hold <= h;
      @(posedge i_ref_clk);
      go <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      chk(32'({o_core_clk_gate, o_core_power_off}), 32'({g, o}));
      repeat (h + 4) @(posedge i_ref_clk);
      chk(32'({o_core_clk_gate, o_core_power_off}), 32'h0);
   endtask
   task automatic complete_run;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      error_cnt++;
      complete_run;
   end
   initial begin
      {i_sys_rst, i_wake_rst, i_avs_read, i_avs_write, go} = 5'h10;
      {i_avs_address, hold, i_avs_writedata} = 48'h0;
      i_avs_byteenable = 4'hF;
      repeat (3) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
      wr(8'h20, 32'h5);
      rd(8'h20, 32'h0);
      chk(32'(resp_q), 32'h3);
      for (int a = 0; a < 4; a++) wr(8'(4 + a * 4), 32'hC3C3_5A00 + a);
      wr(8'h14, 32'hFFFF_FC00);
      repeat (2) @(posedge i_ref_clk);
      chk(32'(o_wake_pin_hys_en), 32'h1);
      rd(8'h14, 32'hFFFF_FC00);
      wr(8'h1C, 32'h3);
      nap(1'b1, 1'b0, 8'h06);
      rd(8'h00, 32'h100);
      rd(8'h18, 32'h1);
      chk(32'(o_irq), 32'h1);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h100);
      wr(8'h00, 32'h100);
      rd(8'h00, 32'h0);
      wr(8'h18, 32'h1);
      repeat (2) @(posedge i_ref_clk);
      chk(32'(o_irq), 32'h0);
      wr(8'h14, 32'hABCD_E800);
      repeat (2) @(posedge i_ref_clk);
      chk(32'(o_wake_pin_hys_en), 32'h0);
      wr(8'h00, 32'h2);
      nap(1'b0, 1'b1, 8'h02);
      @(posedge i_ref_clk);
      i_wake_rst <= 1'b1;
      @(posedge i_ref_clk);
      i_wake_rst <= 1'b0;
      rd(8'h00, 32'h900);
      for (int a = 0; a < 4; a++) rd(8'(4 + a * 4), 32'hC3C3_5A00 + a);
      rd(8'h14, 32'hABCD_E800);
      wr(8'h00, 32'h800);
      rd(8'h00, 32'h100);
      wr(8'h00, 32'h100);
      rd(8'h00, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h1C, 32'h0);
      nap(1'b1, 1'b0, 8'h03);
      chk(32'(o_irq), 32'h0);
      wr(8'h1C, 32'h1);
      repeat (2) @(posedge i_ref_clk);
      chk(32'(o_irq), 32'h1);
      // cold start clears even retained words
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b1;
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      rd(8'h04, 32'h0);
      rd(8'h14, 32'h0);
      complete_run;
   end
endmodule
bind pmu_ctrl_regs pmu_ctrl_checker #(.ADDR_W(ADDR_W)) i_chk (.*);
